// file: sfm_supply_fault_monitor.sv
/*
  Supply fault monitor: synchronises the rail comparators, keeps the
  fault status registers, the overall array fault, the standby request,
  the general-purpose buck controls and a masked interrupt, all but the
  standby request reached over a classic Wishbone slave. Comparator inputs are asynchronous;
  the bus is synchronous to clk_sys.
*/
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sfm_supply_fault_monitor
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // Register bus
  input  wire sfm_pkg::sfm_wb_req_type wb_req,
  output var  sfm_pkg::sfm_wb_rsp_type wb_rsp_q,
  // Analog comparators
  input  wire sfm_pkg::sfm_comp_type   comp_raw,
  // Converter and mode control
  output var  sfm_pkg::sfm_buck_ctl_type gp_buck_ctl_q,
  output logic                         standby_req_q,
  output logic                         irq_q
);
  import sfm_pkg::*;

  // Synchroniser and status flops
  sfm_comp_type comp_meta_q;
  sfm_comp_type comp_sync_q;
  logic [7:0]   array_pg_q;
  logic [7:0]   array_ov_q;
  logic [7:0]   buck_pg_q;
  logic [7:0]   buck_ov_q;
  logic         mirror_fault_q;
  // Software registers
  logic [7:0]   supply_en_q;
  logic [7:0]   setpt_q;
  logic [7:0]   skip_q;
  logic [7:0]   config_q;
  logic [3:0]   irq_stat_q;
  logic [3:0]   irq_en_q;

  // Two flip-flops per comparator; only the second stage is used [R17]
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      comp_meta_q <= '0;
      comp_sync_q <= '0;
    end
    else
    begin
      comp_meta_q <= comp_raw;
      comp_sync_q <= comp_meta_q;
    end
  end

  // Fault levels decoded from synchronised comparators
  wire hv_pg_fault   = comp_sync_q.reset_rail_low |
                       comp_sync_q.offset_rail_low |
                       comp_sync_q.bias_rail_low;              // [R2]
  wire buck_a_pg     = comp_sync_q.array_buck_a_low;           // [R3]
  wire buck_b_pg     = comp_sync_q.array_buck_b_low;           // [R3]
  wire ldo_a_pg      = comp_sync_q.aux_ldo_a_low;              // [R4]
  wire ldo_b_pg      = comp_sync_q.aux_ldo_b_low;              // [R4]
  wire hvs_ldo_pg    = comp_sync_q.hv_support_ldo_low;         // [R5]
  wire bs_ldo_pg     = comp_sync_q.buck_support_ldo_low;       // [R13]
  wire buck_a_ov     = comp_sync_q.array_buck_a_high;          // [R6]
  wire buck_b_ov     = comp_sync_q.array_buck_b_high;          // [R6]
  wire bs_ldo_ov     = comp_sync_q.buck_support_ldo_high;      // [R14]
  // A switched-off buck sits below 72 percent by nature; not a fault
  wire gp_pg_fault   = comp_sync_q.gp_buck_low &
                       supply_en_q[SFM_BIT_GP_BUCK_EN];        // [R12]
  wire gp_ov_fault   = comp_sync_q.gp_buck_high;               // [R15]
  wire aux_gp_mode   = config_q[SFM_BIT_AUX_GP_MODE];

  // Register images; buck 1 and 3 positions stay zero
  wire [7:0] array_pg_d = {1'b0, bs_ldo_pg, hvs_ldo_pg, ldo_b_pg, ldo_a_pg,
                           buck_b_pg, buck_a_pg, hv_pg_fault};
  wire [7:0] array_ov_d = {4'h0, comp_sync_q.aux_ldo_b_high,
                           comp_sync_q.aux_ldo_a_high, buck_b_ov, buck_a_ov};
  wire [7:0] buck_pg_d  = 8'(gp_pg_fault) << SFM_BIT_GP_BUCK;   // [R11]
  wire [7:0] buck_ov_d  = (8'(bs_ldo_ov) << SFM_BIT_BUCK_LDO_OV) |
                          (8'(gp_ov_fault) << SFM_BIT_GP_BUCK); // [R11]

  // Auxiliary LDO overvoltage dropped in general-purpose mode [R7]
  wire [7:0] array_ov_masked = aux_gp_mode ? (array_ov_d & 8'h03)
                                           : array_ov_d;
  wire mirror_fault_d = (|array_pg_d) | (|array_ov_masked);     // [R1]
  wire any_fault_d    = mirror_fault_d | (|buck_pg_d) | (|buck_ov_d);

  // Status follows the faults: set on entry, clears when resolved
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      array_pg_q     <= '0;
      array_ov_q     <= '0;
      buck_pg_q      <= '0;
      buck_ov_q      <= '0;
      mirror_fault_q <= 1'b0;
      standby_req_q  <= 1'b0;
    end
    else
    begin
      array_pg_q     <= array_pg_d;
      array_ov_q     <= array_ov_d;
      buck_pg_q      <= buck_pg_d;
      buck_ov_q      <= buck_ov_d;
      mirror_fault_q <= mirror_fault_d;                        // [R1]
      standby_req_q  <= any_fault_d;                           // [R16]
    end
  end

  // Bus decode; a request is served once, in the cycle after it appears
  wire       bus_req  = wb_req.cyc & wb_req.stb & ~wb_rsp_q.ack;
  wire       bus_wr   = bus_req & wb_req.we & wb_req.sel[0];
  wire [7:0] bus_idx  = wb_req.adr[9:2];
  wire [7:0] wr_byte  = wb_req.dat[7:0];
  wire wr_en    = bus_wr & (bus_idx == SFM_IDX_SUPPLY_EN);
  wire wr_setpt = bus_wr & (bus_idx == SFM_IDX_BUCK_SETPT);
  wire wr_skip  = bus_wr & (bus_idx == SFM_IDX_BUCK_SKIP);
  wire wr_cfg   = bus_wr & (bus_idx == SFM_IDX_MON_CONFIG);
  wire wr_ien   = bus_wr & (bus_idx == SFM_IDX_IRQ_ENABLE);
  wire wr_iclr  = bus_wr & (bus_idx == SFM_IDX_IRQ_CLEAR);

  // Read mux; unmapped and write-only indices read as zero
  function automatic logic [7:0] rd_sel(input logic [7:0] idx,
                                        input logic [7:0] en,
                                        input logic [7:0] ovr,
                                        input logic [7:0] spt,
                                        input logic [7:0] skp,
                                        input logic [7:0] bpg,
                                        input logic [7:0] bov,
                                        input logic [7:0] apg,
                                        input logic [7:0] aov,
                                        input logic [7:0] cfg,
                                        input logic [7:0] ist,
                                        input logic [7:0] ien);
    case (idx)
      SFM_IDX_SUPPLY_EN:  rd_sel = en;
      SFM_IDX_OVERALL:    rd_sel = ovr;
      SFM_IDX_BUCK_SETPT: rd_sel = spt;
      SFM_IDX_BUCK_SKIP:  rd_sel = skp;
      SFM_IDX_BUCK_PG:    rd_sel = bpg;
      SFM_IDX_BUCK_OV:    rd_sel = bov;
      SFM_IDX_ARRAY_PG:   rd_sel = apg;
      SFM_IDX_ARRAY_OV:   rd_sel = aov;
      SFM_IDX_MON_CONFIG: rd_sel = cfg;
      SFM_IDX_IRQ_STATUS: rd_sel = ist;
      SFM_IDX_IRQ_ENABLE: rd_sel = ien;
      default:            rd_sel = 8'h00;
    endcase
  endfunction

  wire [7:0] rd_byte = rd_sel(bus_idx, supply_en_q,
                              8'(mirror_fault_q) << SFM_BIT_MIRROR_FAULT,
                              setpt_q, skip_q, buck_pg_q, buck_ov_q,
                              array_pg_q, array_ov_q, config_q,
                              {4'h0, irq_stat_q}, {4'h0, irq_en_q});

  // Answer every request, mapped or not, one cycle after it is taken
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      wb_rsp_q <= '0;
    else
    begin
      wb_rsp_q.ack <= bus_req;
      wb_rsp_q.dat <= bus_req ? {24'h0, rd_byte} : 32'h0;
    end
  end

  // Writable registers; all bits stored except irq_en_q bits 7:4, only buck 2 fields act
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      supply_en_q <= SFM_RST_SUPPLY_EN;
      setpt_q     <= SFM_RST_SETPT;
      skip_q      <= SFM_RST_SKIP;
      config_q    <= SFM_RST_CONFIG;
      irq_en_q    <= SFM_RST_IRQ;
    end
    else
    begin
      if (wr_en)
        supply_en_q <= wr_byte;                                // [R8]
      if (wr_setpt)
        setpt_q <= wr_byte;                                    // [R9]
      if (wr_skip)
        skip_q <= wr_byte;                                     // [R10]
      if (wr_cfg)
        config_q <= wr_byte;
      if (wr_ien)
        irq_en_q <= wr_byte[3:0];
    end
  end

  // Converter control pins; only buck 2 has hardware behind it
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      gp_buck_ctl_q <= '0;
    else
    begin
      gp_buck_ctl_q.enable   <= supply_en_q[SFM_BIT_GP_BUCK_EN];  // [R8] [R11]
      gp_buck_ctl_q.skip     <= skip_q[SFM_BIT_GP_BUCK];          // [R10] [R11]
      gp_buck_ctl_q.setpoint <= setpt_q;                          // [R9]
    end
  end

  // Rising-edge events; set beats a clear in the same cycle
  wire [3:0] ev_now;
  assign ev_now[SFM_EV_MIRROR]  = mirror_fault_d & ~mirror_fault_q;
  assign ev_now[SFM_EV_GP_PG]   = gp_pg_fault & ~buck_pg_q[SFM_BIT_GP_BUCK];
  assign ev_now[SFM_EV_GP_OV]   = gp_ov_fault & ~buck_ov_q[SFM_BIT_GP_BUCK];
  assign ev_now[SFM_EV_STANDBY] = any_fault_d & ~standby_req_q;
  wire [3:0] irq_clr = wr_iclr ? wr_byte[3:0] : 4'h0;
  wire [3:0] irq_stat_d = (irq_stat_q & ~irq_clr) | ev_now;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      irq_stat_q <= SFM_RST_IRQ;
      irq_q      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_d & irq_en_q);
    end
  end

  // Checks; all on the system clock and idle while reset is high
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_gp_ov_held;
    comp_raw.gp_buck_high [*3];
  endsequence

  sequence s_gp_ov_quiet;
    !comp_raw.gp_buck_high [*3];
  endsequence

  a_sync_ov_late: assert property ( // [R17] [R15]
    (s_gp_ov_quiet ##1 comp_raw.gp_buck_high) |=>
      !buck_ov_q[SFM_BIT_GP_BUCK] [*2])
    else $error("overvoltage status rose before two sync stages");

  a_sync_ov_set: assert property ( // [R15]
    s_gp_ov_held |-> ##1 buck_ov_q[SFM_BIT_GP_BUCK])
    else $error("overvoltage status missed a held comparator");

  a_mirror_follows: assert property ( // [R1]
    (|array_pg_q) |-> mirror_fault_q)
    else $error("array good fault without overall fault");

  a_aux_ov_masked: assert property ( // [R7]
    (aux_gp_mode && $past(aux_gp_mode) && array_pg_q == 8'h00 &&
     array_ov_q[1:0] == 2'b00) |-> !mirror_fault_q)
    else $error("auxiliary overvoltage reached overall fault");

  a_standby_track: assert property ( // [R16]
    (mirror_fault_q || buck_ov_q != 8'h00) |-> standby_req_q)
    else $error("fault present without standby request");

  a_standby_release: assert property ( // [R16]
    $fell(standby_req_q) |-> !mirror_fault_q && buck_ov_q == 8'h00)
    else $error("standby released while a fault stands");

  a_enable_write: assert property ( // [R8]
    wr_en |-> ##2 gp_buck_ctl_q.enable == $past(wr_byte[0], 2))
    else $error("buck enable did not follow the write");

  a_setpt_write: assert property ( // [R9]
    wr_setpt |-> ##2 gp_buck_ctl_q.setpoint == $past(wr_byte, 2))
    else $error("setpoint did not follow the write");

  a_skip_only_b: assert property ( // [R10] [R11]
    wr_skip |-> ##2 gp_buck_ctl_q.skip == $past(wr_byte[1], 2))
    else $error("skip control not taken from buck two bit");

  a_unused_zero: assert property ( // [R11]
    buck_pg_q[0] == 1'b0 && buck_pg_q[2] == 1'b0 && buck_ov_q[0] == 1'b0)
    else $error("unsupported buck shows a fault");

  a_ack_single: assert property (
    wb_rsp_q.ack |=> !wb_rsp_q.ack)
    else $error("ack held longer than one cycle");

  a_irq_set_wins: assert property (
    (ev_now[SFM_EV_GP_OV] && wr_iclr) |=> irq_stat_q[SFM_EV_GP_OV])
    else $error("event lost to a simultaneous clear");

  // A comparator level held for three edges must reach its status bit
  // at the next edge; shorter glitches may be missed by design
  sequence s_hv_rail_held;
    (comp_raw.reset_rail_low || comp_raw.offset_rail_low ||
     comp_raw.bias_rail_low) [*3];
  endsequence

  sequence s_gp_low_on;
    comp_raw.gp_buck_low [*3] ##0 supply_en_q[SFM_BIT_GP_BUCK_EN];
  endsequence

  a_hv_pg_set: assert property ( // [R2]
    s_hv_rail_held |-> ##1 array_pg_q[0])
    else $error("regulator rail fault missed");

  a_buck_a_pg: assert property ( // [R3]
    comp_raw.array_buck_a_low [*3] |-> ##1 array_pg_q[1])
    else $error("array buck a good fault missed");

  a_buck_b_pg: assert property ( // [R3]
    comp_raw.array_buck_b_low [*3] |-> ##1 array_pg_q[2])
    else $error("array buck b good fault missed");

  a_aux_ldo_pg: assert property ( // [R4]
    comp_raw.aux_ldo_b_low [*3] |-> ##1 array_pg_q[4])
    else $error("auxiliary LDO good fault missed");

  a_hvs_ldo_pg: assert property ( // [R5]
    comp_raw.hv_support_ldo_low [*3] |-> ##1 array_pg_q[5])
    else $error("regulator-support LDO good fault missed");

  a_buck_ov_set: assert property ( // [R6]
    comp_raw.array_buck_b_high [*3] |-> ##1 array_ov_q[1])
    else $error("array buck overvoltage missed");

  // Outside general-purpose mode the auxiliary LDOs count as array rails
  a_aux_ov_counted: assert property ( // [R7]
    (!$past(aux_gp_mode) && array_ov_q[3:2] != 2'b00) |-> mirror_fault_q)
    else $error("auxiliary overvoltage dropped in array mode");

  a_gp_pg_set: assert property ( // [R12]
    s_gp_low_on |-> ##1 buck_pg_q[SFM_BIT_GP_BUCK])
    else $error("general-purpose buck good fault missed");

  a_gp_pg_off: assert property ( // [R12]
    !supply_en_q[SFM_BIT_GP_BUCK_EN] |=> !buck_pg_q[SFM_BIT_GP_BUCK])
    else $error("switched-off buck reported low");

  a_bs_ldo_pg: assert property ( // [R13]
    comp_raw.buck_support_ldo_low [*3] |-> ##1 array_pg_q[6])
    else $error("buck-support LDO good fault missed");

  a_bs_ldo_ov: assert property ( // [R14]
    comp_raw.buck_support_ldo_high [*3] |->
      ##1 buck_ov_q[SFM_BIT_BUCK_LDO_OV])
    else $error("buck-support LDO overvoltage missed");

  a_mirror_clear: assert property ( // [R1]
    (array_pg_q == 8'h00 && array_ov_q == 8'h00) |-> !mirror_fault_q)
    else $error("overall fault without a cause");

  a_standby_pg: assert property ( // [R16]
    (buck_pg_q != 8'h00) |-> standby_req_q)
    else $error("buck good fault without standby request");

  a_enable_hold: assert property ( // [R8]
    !wr_en |=> $stable(supply_en_q))
    else $error("buck enable changed without a write");

  // Bus answer timing that software relies on
  a_ack_answer: assert property (
    (wb_req.cyc && wb_req.stb && !wb_rsp_q.ack) |=> wb_rsp_q.ack)
    else $error("request not answered in the next cycle");

  a_rdata_idle: assert property (
    !wb_rsp_q.ack |-> wb_rsp_q.dat == 32'h0)
    else $error("read data driven outside an answer");

  // The pin lags an enable write by one cycle, hence the past enable
  a_irq_level: assert property (
    irq_q == |(irq_stat_q & $past(irq_en_q)))
    else $error("interrupt level disagrees with enabled status");

endmodule // sfm_supply_fault_monitor
`default_nettype wire

// file: sfm_pkg.sv
/*
  Shared constants and types of the supply fault monitor: register
  indices, field positions, reset values, threshold figures and the
  packed carriers for comparator inputs and the classic Wishbone port.
  Assumes a 32-bit classic Wishbone master and a 100 MHz system clock.
*/
// What this block does
// R1 - Overall mirror-array fault bit set while any array good or overvoltage fault
// R2 - Regulator good fault set when reset, offset or bias rail leaves regulation
// R3 - Each array buck good fault set below 72 percent of its setpoint
// R4 - Each array or auxiliary LDO good fault set below 80/60 percent
// R5 - Internal regulator-support LDO good fault reported as its own bit
// R6 - Each array buck overvoltage fault set above 120 percent of setpoint
// R7 - Auxiliary LDO overvoltage ignored by overall fault in general-purpose mode
// R8 - General-purpose buck switched on or off by its enable bit
// R9 - General-purpose buck setpoint is an 8-bit code covering 1 V to 5 V
// R10 - Per-converter bit selects skip mode instead of 600 kHz switching
// R11 - Only the second general-purpose buck exists; other controls do nothing
// R12 - General-purpose buck good fault set below 72 percent of setpoint
// R13 - Buck-support LDO good fault reported in the array good register
// R14 - Buck-support LDO overvoltage fault set above 7.2 V
// R15 - General-purpose buck overvoltage faults set above 120 percent of setpoint
// R16 - Standby requested while any monitored fault is present, released after; auxiliary LDO overvoltage in general-purpose mode does not request it
// R17 - Every comparator output passes two flip-flops before reaching status
`default_nettype none
package sfm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] SFM_IDX_SUPPLY_EN    = 8'h01;
  localparam logic [7:0] SFM_IDX_OVERALL      = 8'h0c;
  localparam logic [7:0] SFM_IDX_BUCK_SETPT   = 8'h14;
  localparam logic [7:0] SFM_IDX_BUCK_SKIP    = 8'h16;
  localparam logic [7:0] SFM_IDX_BUCK_PG      = 8'h27;
  localparam logic [7:0] SFM_IDX_BUCK_OV      = 8'h28;
  localparam logic [7:0] SFM_IDX_ARRAY_PG     = 8'h29;
  localparam logic [7:0] SFM_IDX_ARRAY_OV     = 8'h2a;
  localparam logic [7:0] SFM_IDX_MON_CONFIG   = 8'h40;
  localparam logic [7:0] SFM_IDX_IRQ_STATUS   = 8'h41;
  localparam logic [7:0] SFM_IDX_IRQ_ENABLE   = 8'h42;
  localparam logic [7:0] SFM_IDX_IRQ_CLEAR    = 8'h43;

  // Field positions
  localparam int SFM_BIT_GP_BUCK_EN    = 0;  // supply_enable_control
  localparam int SFM_BIT_MIRROR_FAULT  = 0;  // overall_fault_status
  localparam int SFM_BIT_GP_BUCK       = 1;  // skip, pg and ov of buck 2
  localparam int SFM_BIT_BUCK_LDO_OV   = 3;  // buck_overvoltage_status
  localparam int SFM_BIT_AUX_GP_MODE   = 0;  // monitor config

  // Reset values
  localparam logic [7:0] SFM_RST_SUPPLY_EN  = 8'h00;
  localparam logic [7:0] SFM_RST_SETPT      = 8'h00;
  localparam logic [7:0] SFM_RST_SKIP       = 8'h00;
  localparam logic [7:0] SFM_RST_CONFIG     = 8'h00;
  localparam logic [3:0] SFM_RST_IRQ        = 4'h0;

  // Analog figures, percent of target, mV or kHz (thresholds set in the comparators)
  localparam int SFM_PCT_RESET_RAIL   = 90;
  localparam int SFM_PCT_RAIL_RISE    = 86;
  localparam int SFM_PCT_RAIL_FALL    = 66;
  localparam int SFM_PCT_BUCK_PG      = 72;
  localparam int SFM_PCT_LDO_RISE     = 80;
  localparam int SFM_PCT_LDO_FALL     = 60;
  localparam int SFM_PCT_BUCK_OV      = 120;
  localparam int SFM_MV_BUCK_LDO_OV   = 7200;
  localparam int SFM_MV_SETPT_MIN     = 1000;
  localparam int SFM_MV_SETPT_MAX     = 5000;
  localparam int SFM_KHZ_NORMAL_SW    = 600;

  // Interrupt event bits
  localparam int SFM_EV_MIRROR  = 0;
  localparam int SFM_EV_GP_PG   = 1;
  localparam int SFM_EV_GP_OV   = 2;
  localparam int SFM_EV_STANDBY = 3;

  // Raw comparator outputs, high while the condition holds
  typedef struct packed {
    logic reset_rail_low;
    logic offset_rail_low;
    logic bias_rail_low;
    logic array_buck_a_low;
    logic array_buck_b_low;
    logic array_buck_a_high;
    logic array_buck_b_high;
    logic aux_ldo_a_low;
    logic aux_ldo_b_low;
    logic aux_ldo_a_high;
    logic aux_ldo_b_high;
    logic hv_support_ldo_low;
    logic gp_buck_low;
    logic gp_buck_high;
    logic buck_support_ldo_low;
    logic buck_support_ldo_high;
  } sfm_comp_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [9:0]  adr;
    logic [31:0] dat;
  } sfm_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } sfm_wb_rsp_type;

  typedef struct packed {
    logic       enable;
    logic       skip;
    logic [7:0] setpoint;
  } sfm_buck_ctl_type;

endpackage
`default_nettype wire

// file: sfm_supply_fault_monitor_tb.sv
/*
  Self-checking bench for the supply fault monitor: register accesses
  over classic Wishbone, comparator stimulus and checks of the status,
  control, standby and interrupt outputs.
  Assumes sfm_pkg is compiled first and the design answers every access.
*/
`timescale 1ns/1ps
`default_nettype none
module sfm_supply_fault_monitor_tb;
  import sfm_pkg::*;

  logic             clk_sys;
  logic             reset;
  sfm_wb_req_type   wb_req;
  sfm_wb_rsp_type   wb_rsp_q;
  sfm_comp_type     comp_raw;
  sfm_buck_ctl_type gp_buck_ctl_q;
  logic             standby_req_q;
  logic             irq_q;
  int               fail_count;
  int               check_count;
  int               i;
  logic [31:0]      bus_d;

  // Expected register and value per comparator bit, LSB first
  logic [7:0] t_reg [16] = '{8'h28, 8'h29, 8'h28, 8'h27, 8'h29, 8'h2a,
    8'h2a, 8'h29, 8'h29, 8'h2a, 8'h2a, 8'h29, 8'h29, 8'h29, 8'h29, 8'h29};
  logic [7:0] t_val [16] = '{8'h08, 8'h40, 8'h02, 8'h02, 8'h20, 8'h08,
    8'h04, 8'h10, 8'h08, 8'h02, 8'h01, 8'h04, 8'h02, 8'h01, 8'h01, 8'h01};
  // Buck-side faults stay out of the overall array fault
  logic       t_mir [16] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
    1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [7:0] rst_idx [11] = '{8'h01, 8'h0c, 8'h14, 8'h16, 8'h27, 8'h28,
    8'h29, 8'h2a, 8'h40, 8'h41, 8'h42};

  sfm_supply_fault_monitor dut_u
  (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .wb_req        (wb_req),
    .wb_rsp_q      (wb_rsp_q),
    .comp_raw      (comp_raw),
    .gp_buck_ctl_q (gp_buck_ctl_q),
    .standby_req_q (standby_req_q),
    .irq_q         (irq_q)
  );

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  // Verdict and end of run; also reached when a wait runs out
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; ack is registered, so the value read at the edge
  // is the one launched by the previous edge and no race is possible
  task automatic bus(input logic we, input logic [3:0] sel,
                     input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rdat);
    int n;
    @(posedge clk_sys);
    wb_req.cyc <= 1'b1;
    wb_req.stb <= 1'b1;
    wb_req.we  <= we;
    wb_req.sel <= sel;
    wb_req.adr <= {idx, 2'b00};
    wb_req.dat <= {24'h000000, wd};
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_sys);
      if (wb_rsp_q.ack === 1'b1)
        break;
    end
    if (n == 20)
    begin
      check("bus ack", 32'h0, 32'h1);
      stop_test();
    end
    rdat = wb_rsp_q.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    wb_req.we  <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    bus(1'b1, 4'h1, idx, wd, d);
  endtask

  task automatic rdchk(input string name, input logic [7:0] idx,
                       input logic [7:0] exp);
    logic [31:0] d;
    bus(1'b0, 4'h1, idx, 8'h00, d);
    check(name, d, {24'h000000, exp});
  endtask

  // Raise one comparator pattern and let it pass the synchronisers
  task automatic comp_set(input logic [15:0] v);
    @(posedge clk_sys);
    comp_raw <= v;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // Main sequence
  initial
  begin
    clk_sys = 1'b0;
    reset = 1'b1;
    wb_req = '0;
    comp_raw = '0;
    fail_count = 0;
    check_count = 0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("outputs after reset", {gp_buck_ctl_q, standby_req_q, irq_q}, 0);
    for (i = 0; i < 11; i++)
      rdchk("reset value", rst_idx[i], 8'h00);
    // Buck controls, both setpoint extremes, the unsupported skip bits
    wr(8'h01, 8'h01);
    #1 check("buck enable", gp_buck_ctl_q.enable, 1'b1);
    rdchk("enable reg", 8'h01, 8'h01);
    wr(8'h14, 8'hff);
    #1 check("setpoint", gp_buck_ctl_q.setpoint, 8'hff);
    wr(8'h14, 8'h00);
    #1 check("setpoint", gp_buck_ctl_q.setpoint, 8'h00);
    // A write without the low byte lane must leave the register alone
    bus(1'b1, 4'h2, 8'h14, 8'h55, bus_d);
    #1 check("no byte lane", gp_buck_ctl_q.setpoint, 8'h00);
    wr(8'h16, 8'h05);
    #1 check("skip other", gp_buck_ctl_q.skip, 1'b0);
    wr(8'h16, 8'h02);
    #1 check("skip", gp_buck_ctl_q.skip, 1'b1);
    rdchk("skip reg", 8'h16, 8'h02);
    // Read-only, write-only and unmapped places
    wr(8'h0c, 8'hff);
    rdchk("ro write", 8'h0c, 8'h00);
    rdchk("unmapped", 8'h3f, 8'h00);
    rdchk("clear reads", 8'h43, 8'h00);
    wr(8'h42, 8'h0f);
    // Every comparator alone: two-stage delay, status bit, overall fault
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk_sys);
      comp_raw <= 16'h0001 << i;
      repeat (2) @(posedge clk_sys);
      #1 check("early standby", standby_req_q, 1'b0);
      @(posedge clk_sys);
      #1 check("standby", standby_req_q, 1'b1);
      rdchk("fault bit", t_reg[i], t_val[i]);
      rdchk("mirror", 8'h0c, {7'h00, t_mir[i]});
      comp_set(16'h0000);
      check("standby gone", standby_req_q, 1'b0);
    end
    // Sticky interrupt status, clear, then a masked event
    check("irq", irq_q, 1'b1);
    rdchk("irq status", 8'h41, 8'h0f);
    wr(8'h43, 8'h0f);
    #1 check("irq cleared", irq_q, 1'b0);
    rdchk("irq status", 8'h41, 8'h00);
    wr(8'h42, 8'h00);
    comp_set(16'h0004);
    check("irq masked", irq_q, 1'b0);
    rdchk("irq status", 8'h41, 8'h0c);
    comp_set(16'h0000);
    wr(8'h43, 8'h0f);
    // Event and clear taken at one edge: the event must survive
    @(posedge clk_sys);
    comp_raw <= 16'h0004;
    @(posedge clk_sys);
    wr(8'h43, 8'h0f);
    rdchk("set beats clear", 8'h41, 8'h0c);
    comp_set(16'h0000);
    wr(8'h43, 8'h0f);
    // Auxiliary LDO overvoltage in general-purpose mode
    wr(8'h40, 8'h01);
    comp_set(16'h0040);
    rdchk("aux ov gp", 8'h0c, 8'h00);
    rdchk("aux ov bit", 8'h2a, 8'h04);
    comp_set(16'h0000);
    // A switched-off buck reports no low output
    wr(8'h01, 8'h00);
    #1 check("buck off", gp_buck_ctl_q.enable, 1'b0);
    comp_set(16'h0008);
    rdchk("pg when off", 8'h27, 8'h00);
    comp_set(16'h0000);
    stop_test();
  end
endmodule // sfm_supply_fault_monitor_tb
`default_nettype wire
